// File: pkg/dit_pkg.sv
// Package with register map, field positions and timing constants of the interval timer.
package dit_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_OFF = 8'h00;
    localparam logic [7:0] CNT_HI_OFF = 8'hA4;
    localparam logic [7:0] CNT_LO_OFF = 8'hA8;
    localparam logic [7:0] STAT_OFF = 8'h04;
    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int BEGIN_BIT_POS = 5;
    localparam int HALT_BIT_POS = 4;
    localparam logic [15:0] CNT_HALF_RST = 16'hFFFF;
    localparam logic [31:0] CNT_ALL_ONES = 32'hFFFFFFFF;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int TICK_CYCLES = 4;
    localparam logic [1:0] TICK_LAST = 2'(TICK_CYCLES - 1);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        DIT_IDLE = 2'b01,
        DIT_RUN = 2'b10
    } dit_state_t;
endpackage

// File: pkg/dit_cnt_if.sv
// Interface between the register slave and the tick counter core.
`timescale 1ns/1ps
interface dit_cnt_if;
    logic run;
    logic wr_hi;
    logic wr_lo;
    logic [15:0] wdata;
    logic [31:0] count;
    logic running;
    modport ctl (output run, output wr_hi, output wr_lo, output wdata, input count, input running);
    modport core (input run, input wr_hi, input wr_lo, input wdata, output count, output running);
endinterface

// File: verilog/dit_core.sv
// Tick prescaler and 32-bit down-counter core.
`timescale 1ns/1ps
module dit_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    dit_cnt_if.core cif
);
    typedef struct packed {
        dit_pkg::dit_state_t state;
        logic [1:0] pre;
        logic [31:0] cnt;
    } dit_core_st_t;

    dit_core_st_t st_ff;
    dit_core_st_t nxt_st;

    function automatic logic [31:0] dec32(input logic [31:0] v);
        dec32 = v - 32'h00000001;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        case (st_ff.state)
            dit_pkg::DIT_IDLE: begin
                nxt_st.pre = 2'h0;
                if (cif.run) begin
                    nxt_st.state = dit_pkg::DIT_RUN;
                end
            end
            dit_pkg::DIT_RUN: begin
                if (!cif.run) begin
                    nxt_st.state = dit_pkg::DIT_IDLE;
                end else begin
                    nxt_st.pre = st_ff.pre + 2'h1;
                    if (st_ff.pre == dit_pkg::TICK_LAST) begin
                        // Zero steps to all ones through the natural wrap.
                        nxt_st.cnt = dec32(st_ff.cnt);
                    end
                end
            end
            default: begin
                nxt_st.state = dit_pkg::DIT_IDLE;
            end
        endcase
        // Software writes take precedence over a tick in the same cycle.
        if (cif.wr_hi) begin
            nxt_st.cnt[31:16] = cif.wdata;
        end
        if (cif.wr_lo) begin
            nxt_st.cnt[15:0] = cif.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{dit_pkg::DIT_IDLE, 2'h0, dit_pkg::CNT_ALL_ONES};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cif.count = st_ff.cnt;
    assign cif.running = (st_ff.state == dit_pkg::DIT_RUN);
endmodule

// File: verilog/dit_top.sv
// AXI4-Lite register slave of the interval down-counter.
`timescale 1ns/1ps
// Functional notes
// - The count is 32 bits held as an upper and a lower 16-bit register.
// - While running the count drops by one every four clock cycles.
// - Writing the command register with the begin bit set and the halt bit clear starts counting.
// - Writing the command register with the halt bit set freezes both halves.
module dit_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ------------------------------------------------------------------
    // Slave state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic run;
        logic wr_hi;
        logic wr_lo;
        logic [15:0] wdata;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
    } dit_slv_st_t;

    // Ready flags are kept as their own flops so every bus output comes from a register.
    localparam dit_slv_st_t SLV_RST = '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};

    dit_slv_st_t st_ff;
    dit_slv_st_t nxt_st;
    dit_cnt_if cif ();

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == dit_pkg::CMD_OFF) || (a == dit_pkg::CNT_HI_OFF)
            || (a == dit_pkg::CNT_LO_OFF) || (a == dit_pkg::STAT_OFF);
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.wr_hi = 1'b0;
        nxt_st.wr_lo = 1'b0;
        // Each channel is taken on its own; the write completes once both are held.
        if (s_axi_awvalid && !st_ff.aw_have) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_have) begin
            nxt_st.w_have = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = addr_ok(st_ff.aw_addr) ? dit_pkg::RESP_OKAY : dit_pkg::RESP_SLVERR;
            nxt_st.wdata = st_ff.w_data[15:0];
            case (st_ff.aw_addr)
                dit_pkg::CMD_OFF: begin
                    // Halt wins when both bits are written together, so a stray
                    // begin never restarts a measurement being read out.
                    if (st_ff.w_strb[0] && st_ff.w_data[dit_pkg::HALT_BIT_POS]) begin
                        nxt_st.run = 1'b0;
                    end else if (st_ff.w_strb[0] && st_ff.w_data[dit_pkg::BEGIN_BIT_POS]) begin
                        nxt_st.run = 1'b1;
                    end
                end
                dit_pkg::CNT_HI_OFF: begin
                    nxt_st.wr_hi = &st_ff.w_strb[1:0];
                end
                dit_pkg::CNT_LO_OFF: begin
                    nxt_st.wr_lo = &st_ff.w_strb[1:0];
                end
                default: begin
                    nxt_st.wr_hi = 1'b0;
                end
            endcase
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // Read path: address taken only while no read data is pending.
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = addr_ok(s_axi_araddr) ? dit_pkg::RESP_OKAY : dit_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                dit_pkg::CMD_OFF: begin
                    nxt_st.rdata = 32'h00000000;
                end
                dit_pkg::STAT_OFF: begin
                    nxt_st.rdata = {31'h00000000, cif.running};
                end
                dit_pkg::CNT_HI_OFF: begin
                    nxt_st.rdata = {16'h0000, cif.count[31:16]};
                end
                dit_pkg::CNT_LO_OFF: begin
                    nxt_st.rdata = {16'h0000, cif.count[15:0]};
                end
                default: begin
                    nxt_st.rdata = 32'h00000000;
                end
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        nxt_st.aw_rdy = !nxt_st.aw_have;
        nxt_st.w_rdy = !nxt_st.w_have;
        nxt_st.ar_rdy = !nxt_st.rvalid;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= SLV_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Counter core
    // ------------------------------------------------------------------
    assign cif.run = st_ff.run;
    assign cif.wr_hi = st_ff.wr_hi;
    assign cif.wr_lo = st_ff.wr_lo;
    assign cif.wdata = st_ff.wdata;

    dit_core u_core (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cif(cif)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = st_ff.aw_rdy;
    assign s_axi_wready = st_ff.w_rdy;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.ar_rdy;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
endmodule

// File: tb/dit_top_properties.sv
// Concurrent checks on the register bus of the interval down-counter.
`timescale 1ns/1ps
module dit_top_properties (
    // Clock and reset
    input wire logic sys_clk, rstn,
    // Write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid, s_axi_bready,
    // Read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    // ------------------------------------------------------------------
    // Address capture
    // ------------------------------------------------------------------
    logic [7:0] wa_ff;
    logic [7:0] ra_ff;
    function automatic logic hit(logic [7:0] a);
        return a == dit_pkg::CMD_OFF || a == dit_pkg::STAT_OFF
            || a == dit_pkg::CNT_HI_OFF || a == dit_pkg::CNT_LO_OFF;
    endfunction
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wa_ff <= 8'h00;
            ra_ff <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
            if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data missing");
    bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rdata_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    ar_block_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    upper_zero_a: assert property (
        s_axi_rvalid && !ra_ff[1] && ra_ff[7] |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("count half wider than 16 bits");
    rd_unmapped_a: assert property (s_axi_rvalid && !hit(ra_ff)
        |-> s_axi_rresp == dit_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    wr_resp_a: assert property ($rose(s_axi_bvalid)
        |-> s_axi_bresp == (hit(wa_ff) ? dit_pkg::RESP_OKAY : dit_pkg::RESP_SLVERR))
        else $error("write response code wrong");
endmodule
bind dit_top dit_top_properties u_props (.*);

// File: tb/dit_top_bench.sv
// Self-checking bench of the interval down-counter.
`timescale 1ns/1ps
module dit_top_bench;
    localparam logic [31:0] GO = 32'h00000001 << dit_pkg::BEGIN_BIT_POS;
    localparam logic [31:0] HALT = 32'h00000001 << dit_pkg::HALT_BIT_POS;
    localparam logic [1:0] OK = dit_pkg::RESP_OKAY;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] aa = 8'h00, ar = 8'h00;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [3:0] ws = 4'h0;
    logic awr, wrd, bv, arr, rv;
    logic [1:0] br, rr;
    logic [31:0] rdd;
    logic [33:0] exp_q[$];
    logic [15:0] lf = 16'hC18E;
    int fail_count = 0, samples_checked = 0, cyc = 0, t0 = 0;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    dit_top DUT (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(string n, logic [33:0] s, logic [33:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // The monitor takes the oldest note whenever a response is handed over.
    always @(posedge sys_clk) begin
        if (bv && bre) check("bresp", {br, 32'h00000000}, exp_q.pop_front());
        if (rv && rre) check("rdata", {rr, rdd}, exp_q.pop_front());
    end
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
        logic pa, pw;
        @(posedge sys_clk);
        aa <= a;
        wd <= d;
        ws <= 4'hF;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        exp_q.push_back({e, 32'h00000000});
        t0 = cyc;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(posedge sys_clk);
            if (pa && awr) begin
                awv <= 1'b0;
                pa = 1'b0;
            end
            if (pw && wrd) begin
                wv <= 1'b0;
                pw = 1'b0;
            end
        end
        while (!bv) @(posedge sys_clk);
        bre <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [1:0] e, logic [31:0] d);
        @(posedge sys_clk);
        ar <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        exp_q.push_back({e, d});
        do @(posedge sys_clk); while (!arr);
        arv <= 1'b0;
        while (!rv) @(posedge sys_clk);
        rre <= 1'b0;
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] v, e;
        int k;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        wr(dit_pkg::CMD_OFF, GO, OK);
        rd(dit_pkg::STAT_OFF, OK, 32'h00000001);
        rd(dit_pkg::CMD_OFF, OK, 32'h00000000);
        wr(dit_pkg::CNT_HI_OFF, 32'h0000FFFF, OK);
        wr(dit_pkg::CNT_LO_OFF, 32'h0000FFFF, OK);
        wr(dit_pkg::CMD_OFF, HALT, OK);
        rd(dit_pkg::CNT_HI_OFF, OK, 32'h0000FFFF);
        // Run spans of 4k+2 cycles so a one-cycle skew cannot move the tick count.
        for (int i = 0; i < 6; i++) begin
            lf = lfsr(lf);
            v = {lf, 16'h0000};
            lf = lfsr(lf);
            v[15:0] = lf;
            k = 1 + lf[2:0];
            if (i == 0) begin
                v = 32'h00000002;
                k = 5;
            end
            wr(dit_pkg::CNT_HI_OFF, {16'h0000, v[31:16]}, OK);
            wr(dit_pkg::CNT_LO_OFF, {16'h0000, v[15:0]}, OK);
            wr(dit_pkg::CMD_OFF, GO, OK);
            while (cyc < t0 + 4 * k + 1) @(posedge sys_clk);
            wr(dit_pkg::CMD_OFF, HALT, OK);
            e = v - 32'(k);
            repeat (8) @(posedge sys_clk);
            rd(dit_pkg::CNT_HI_OFF, OK, {16'h0000, e[31:16]});
            rd(dit_pkg::CNT_LO_OFF, OK, {16'h0000, e[15:0]});
            repeat (9) @(posedge sys_clk);
            rd(dit_pkg::CNT_LO_OFF, OK, {16'h0000, e[15:0]});
            rd(dit_pkg::STAT_OFF, OK, 32'h00000000);
        end
        wr(dit_pkg::CMD_OFF, GO, OK);
        wr(dit_pkg::CMD_OFF, GO | HALT, OK);
        rd(dit_pkg::STAT_OFF, OK, 32'h00000000);
        wr(8'h10, 32'h00000000, dit_pkg::RESP_SLVERR);
        rd(8'h10, dit_pkg::RESP_SLVERR, 32'h00000000);
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        end_sim;
    end
endmodule
